// *** hw/rcs_pkg.sv ***
// constants, layouts and types of the reset and clock sequencer
package rcs_pkg;

    // oscillator clock and derived timing counts
    localparam int unsigned OSC_FREQ_HZ    = 10_000_000;
    localparam int unsigned OSC_START_NS   = 3000;
    localparam int unsigned OSC_START_CYC  = (OSC_START_NS * (OSC_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned POR_PULSE_US   = 600;
    localparam int unsigned POR_PULSE_CYC  = POR_PULSE_US * (OSC_FREQ_HZ / 1_000_000);
    localparam int unsigned WDOG_PULSE_CYC = 512;
    localparam int unsigned WARM_MIN_CYC   = 32;
    localparam int unsigned BUS_VALID_CYC  = 32;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL     = 5'h00;
    localparam logic [4:0] OFS_PLL_MULT = 5'h04;
    localparam logic [4:0] OFS_LOCK_PRD = 5'h08;
    localparam logic [4:0] OFS_STATUS   = 5'h0C;

    // system clock divide select codes
    localparam logic [1:0] SYSTEM_CLOCK_DIVIDE_SELECT_DIV4A = 2'h0;
    localparam logic [1:0] SYSTEM_CLOCK_DIVIDE_SELECT_DIV4B = 2'h1;
    localparam logic [1:0] SYSTEM_CLOCK_DIVIDE_SELECT_DIV2  = 2'h2;
    localparam logic [1:0] SYSTEM_CLOCK_DIVIDE_SELECT_DIV1  = 2'h3;

    // reset values
    localparam logic [1:0]  SYSTEM_CLOCK_DIVIDE_SELECT_RST   = 2'h0;
    localparam logic [1:0]  XDIV_RST     = 2'h0;
    localparam logic        XEN_RST      = 1'b0;
    localparam logic [4:0]  PLL_MULT_RST = 5'h00;
    localparam logic [15:0] LOCK_PRD_RST = 16'h2710;

    typedef struct packed {
        logic       clock_output_enable;
        logic [1:0] clock_output_divider;
        logic [1:0] system_clock_divide_select;
    } rcs_ctrl_t;

    typedef enum logic [2:0] {
        ST_OSC_START = 3'b000,
        ST_POR_DRIVE = 3'b001,
        ST_PIN_WAIT  = 3'b011,
        ST_POST_WAIT = 3'b010,
        ST_RUN       = 3'b110,
        ST_WDOG      = 3'b111,
        ST_EXT_LOW   = 3'b101
    } rcs_state_t;

    typedef enum logic [1:0] {
        CAUSE_POR  = 2'h0,
        CAUSE_WDOG = 2'h1,
        CAUSE_WARM = 2'h2
    } rcs_cause_t;

    typedef struct packed {
        rcs_cause_t cause;
        logic [3:0] boot_mode;
        logic       pll_locking;
        rcs_state_t state;
    } rcs_status_t;

endpackage

// *** hw/rcs_sequencer.sv ***
// reset and clock start-up sequencer with an avalon-mm register slave
// Summary of operation
// - system clock oscillator/4 after power-up
// - clock output divider resets zero, output osc/16
// - boot step selects divide-by-one, output osc/4
// - clock output pin idle until software enables
// - sample boot-mode pins after reset release
// - power-on reset drives pin low 600 us
// - watchdog reset pulse lasts 512 cycles
// - bus valid 32 cycles after pin high
// - wait 3 us for oscillator start
// - after lock run programmed multiplied rate
// - pulls enabled only after brown-out release
//
// Our own choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps

module rcs_sequencer #(
    parameter logic [15:0] POR_PULSE_CYCLES = 16'(rcs_pkg::POR_PULSE_CYC)
) (
    input  wire logic        ref_clk,
    input  wire logic        rst_n,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        external_reset_pin_in,
    output logic             external_reset_pin_out,
    output logic             external_reset_pin_oe,
    input  wire logic        brownout_reset_n,
    input  wire logic        watchdog_expire,
    input  wire logic [3:0]  boot_mode_pins,
    output logic      [3:0]  boot_mode,
    output logic             boot_mode_valid,
    output logic             core_reset_n,
    output logic             bus_valid,
    output logic             pull_enable,
    output logic             clock_output_pin,
    output logic      [4:0]  sysclk_num,
    output logic      [3:0]  sysclk_den,
    output logic             pll_locking
);

    localparam logic [15:0] OSC_START_LAST = 16'(rcs_pkg::OSC_START_CYC - 1);
    localparam logic [15:0] WDOG_LAST      = 16'(rcs_pkg::WDOG_PULSE_CYC - 1);
    localparam logic [15:0] WARM_LAST      = 16'(rcs_pkg::WARM_MIN_CYC - 1);
    localparam logic [15:0] BUS_VALID_LAST = 16'(rcs_pkg::BUS_VALID_CYC - 1);
    localparam logic [15:0] POR_LAST       = POR_PULSE_CYCLES - 16'h0001;

    // divide factor of the system clock divide select
    function automatic logic [3:0] sys_div(input logic [1:0] sel);
        case (sel)
            rcs_pkg::SYSTEM_CLOCK_DIVIDE_SELECT_DIV2: sys_div = 4'h2;
            rcs_pkg::SYSTEM_CLOCK_DIVIDE_SELECT_DIV1: sys_div = 4'h1;
            default:              sys_div = 4'h4;
        endcase
    endfunction

    // divide factor of the clock output divider
    function automatic logic [3:0] out_div(input logic [1:0] sel);
        case (sel)
            2'h0:    out_div = 4'h4;
            2'h1:    out_div = 4'h2;
            default: out_div = 4'h1;
        endcase
    endfunction

    // two-flop synchronisers: bit 0 reset pin, bit 1 brown-out release
    logic [1:0] sync_meta;
    logic [1:0] sync_out;
    wire  [1:0] async_in = {brownout_reset_n, external_reset_pin_in};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_sync
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    sync_meta[gi] <= 1'b0;
                    sync_out[gi]  <= 1'b0;
                end else begin
                    sync_meta[gi] <= async_in[gi];
                    sync_out[gi]  <= sync_meta[gi];
                end
            end
        end
    endgenerate

    wire pin_high     = sync_out[0];
    wire brownout_rel = sync_out[1];

    // sequencer state
    rcs_pkg::rcs_state_t state;
    rcs_pkg::rcs_state_t next_state;
    rcs_pkg::rcs_cause_t cause;
    rcs_pkg::rcs_cause_t next_cause;
    logic [15:0]         cnt;
    logic [15:0]         next_cnt;

    wire cnt_done = (cnt == 16'h0000);

    always_comb begin
        next_state = state;
        next_cause = cause;
        next_cnt   = (cnt == 16'h0000) ? cnt : cnt - 16'h0001;
        case (state)
            rcs_pkg::ST_OSC_START: begin
                if (cnt_done) begin
                    next_state = rcs_pkg::ST_POR_DRIVE;
                    next_cnt   = POR_LAST;
                end
            end
            rcs_pkg::ST_POR_DRIVE: begin
                if (cnt_done) begin
                    next_state = rcs_pkg::ST_PIN_WAIT;
                end
            end
            rcs_pkg::ST_PIN_WAIT: begin
                // a board that leaves the pin floating relies on its pull-up here
                if (pin_high) begin
                    next_state = rcs_pkg::ST_POST_WAIT;
                    next_cnt   = BUS_VALID_LAST;
                end
            end
            rcs_pkg::ST_POST_WAIT: begin
                if (!pin_high) begin
                    next_state = rcs_pkg::ST_PIN_WAIT;
                end else if (cnt_done) begin
                    next_state = rcs_pkg::ST_RUN;
                end
            end
            rcs_pkg::ST_RUN: begin
                if (watchdog_expire) begin
                    next_state = rcs_pkg::ST_WDOG;
                    next_cause = rcs_pkg::CAUSE_WDOG;
                    next_cnt   = WDOG_LAST;
                end else if (!pin_high) begin
                    next_state = rcs_pkg::ST_EXT_LOW;
                    next_cnt   = 16'h0001;
                end
            end
            rcs_pkg::ST_EXT_LOW: begin
                // shorter low pulses are glitches and leave the core running
                if (pin_high) begin
                    next_state = rcs_pkg::ST_RUN;
                end else if (cnt == WARM_LAST) begin
                    next_state = rcs_pkg::ST_PIN_WAIT;
                    next_cause = rcs_pkg::CAUSE_WARM;
                end else begin
                    next_cnt = cnt + 16'h0001;
                end
            end
            rcs_pkg::ST_WDOG: begin
                if (cnt_done) begin
                    next_state = rcs_pkg::ST_PIN_WAIT;
                end
            end
            default: begin
                next_state = rcs_pkg::ST_OSC_START;
                next_cnt   = OSC_START_LAST;
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= rcs_pkg::ST_OSC_START;
            cause <= rcs_pkg::CAUSE_POR;
            cnt   <= OSC_START_LAST;
        end else begin
            state <= next_state;
            cause <= next_cause;
            cnt   <= next_cnt;
        end
    end

    wire run       = (state == rcs_pkg::ST_RUN) || (state == rcs_pkg::ST_EXT_LOW);
    wire next_run  = (next_state == rcs_pkg::ST_RUN) || (next_state == rcs_pkg::ST_EXT_LOW);
    wire enter_run = (state == rcs_pkg::ST_POST_WAIT) && (next_state == rcs_pkg::ST_RUN);
    // pin stays low through oscillator start so the power-on pulse has no gap
    wire next_drive = (next_state == rcs_pkg::ST_OSC_START) ||
                      (next_state == rcs_pkg::ST_POR_DRIVE) || (next_state == rcs_pkg::ST_WDOG);

    // avalon slave: one wait cycle, then answer for one cycle
    wire req      = avs_read || avs_write;
    wire wr_take  = avs_write && !avs_waitrequest && run;
    wire wr_ctrl  = wr_take && (avs_address == rcs_pkg::OFS_CTRL);
    wire wr_mult  = wr_take && (avs_address == rcs_pkg::OFS_PLL_MULT);
    wire wr_lock  = wr_take && (avs_address == rcs_pkg::OFS_LOCK_PRD);

    rcs_pkg::rcs_ctrl_t ctrl;
    logic [4:0]         pll_mult;
    logic [15:0]        lock_prd;
    logic [15:0]        lock_cnt;
    logic               locking;

    rcs_pkg::rcs_status_t status;
    assign status = '{cause: cause, boot_mode: boot_mode, pll_locking: locking, state: state};

    logic [31:0] rd_mux;
    always_comb begin
        case (avs_address)
            rcs_pkg::OFS_CTRL:     rd_mux = {27'h000_0000, ctrl};
            rcs_pkg::OFS_PLL_MULT: rd_mux = {27'h000_0000, pll_mult};
            rcs_pkg::OFS_LOCK_PRD: rd_mux = {16'h0000, lock_prd};
            rcs_pkg::OFS_STATUS:   rd_mux = {22'h00_0000, status};
            default:               rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !(req && avs_waitrequest);
            avs_readdata    <= (avs_read && avs_waitrequest) ? rd_mux : 32'h0000_0000;
        end
    end

    // configuration returns to reset values for every reset of the core
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl     <= '{rcs_pkg::XEN_RST, rcs_pkg::XDIV_RST, rcs_pkg::SYSTEM_CLOCK_DIVIDE_SELECT_RST};
            pll_mult <= rcs_pkg::PLL_MULT_RST;
            lock_prd <= rcs_pkg::LOCK_PRD_RST;
        end else if (enter_run) begin
            ctrl.system_clock_divide_select <= rcs_pkg::SYSTEM_CLOCK_DIVIDE_SELECT_DIV1;
        end else if (!run) begin
            ctrl     <= '{rcs_pkg::XEN_RST, rcs_pkg::XDIV_RST, rcs_pkg::SYSTEM_CLOCK_DIVIDE_SELECT_RST};
            pll_mult <= rcs_pkg::PLL_MULT_RST;
            lock_prd <= rcs_pkg::LOCK_PRD_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl <= rcs_pkg::rcs_ctrl_t'(avs_writedata[4:0]);
            end
            if (wr_mult) begin
                pll_mult <= avs_writedata[4:0];
            end
            if (wr_lock) begin
                lock_prd <= avs_writedata[15:0];
            end
        end
    end

    // lock phase counted in oscillator cycles from the programmed period
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            locking  <= 1'b0;
            lock_cnt <= 16'h0000;
        end else if (!run) begin
            locking  <= 1'b0;
            lock_cnt <= 16'h0000;
        end else if (wr_mult) begin
            locking  <= (lock_prd != 16'h0000);
            lock_cnt <= lock_prd;
        end else if (locking) begin
            lock_cnt <= lock_cnt - 16'h0001;
            locking  <= (lock_cnt != 16'h0001);
        end
    end

    // system clock rate as numerator and denominator of the oscillator clock
    wire [3:0] cur_div = sys_div(ctrl.system_clock_divide_select);
    logic [4:0] next_num;
    logic [3:0] next_den;
    always_comb begin
        if (!run) begin
            next_num = 5'h01;
            next_den = 4'h4;
        end else if (locking) begin
            next_num = 5'h01;
            next_den = 4'h2;
        end else if (pll_mult != 5'h00) begin
            next_num = pll_mult;
            next_den = 4'(cur_div << 1);
        end else begin
            next_num = 5'h01;
            next_den = cur_div;
        end
    end

    // clock output half period in oscillator cycles; a multiplied rate, or one above osc/2, gives osc/2
    wire [7:0] out_ratio = 8'(next_den) * 8'(out_div(ctrl.clock_output_divider));
    wire [7:0] half_raw  = out_ratio >> 1;
    wire [7:0] half_prd  = (next_num == 5'h01 && half_raw != 8'h00) ? half_raw : 8'h01;
    wire       xout_on   = run && ctrl.clock_output_enable;
    logic [7:0] xout_cnt;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_output_pin <= 1'b0;
            xout_cnt         <= 8'h00;
        end else if (!xout_on) begin
            clock_output_pin <= 1'b0;
            xout_cnt         <= 8'h00;
        end else if (xout_cnt + 8'h01 >= half_prd) begin
            clock_output_pin <= !clock_output_pin;
            xout_cnt         <= 8'h00;
        end else begin
            xout_cnt <= xout_cnt + 8'h01;
        end
    end

    // pin, status and clock-rate outputs
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            external_reset_pin_out <= 1'b0;
            external_reset_pin_oe  <= 1'b1;
            core_reset_n           <= 1'b0;
            bus_valid              <= 1'b0;
            pull_enable            <= 1'b0;
            sysclk_num             <= 5'h01;
            sysclk_den             <= 4'h4;
            pll_locking            <= 1'b0;
        end else begin
            external_reset_pin_out <= 1'b0;
            external_reset_pin_oe  <= next_drive;
            core_reset_n           <= next_run;
            bus_valid              <= next_run;
            pull_enable            <= brownout_rel;
            sysclk_num             <= next_num;
            sysclk_den             <= next_den;
            pll_locking            <= locking;
        end
    end

    // boot pins caught once at release; board keeps them steady meanwhile
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_mode       <= 4'h0;
            boot_mode_valid <= 1'b0;
        end else begin
            if (enter_run) begin
                boot_mode <= boot_mode_pins;
            end
            boot_mode_valid <= next_run;
        end
    end

endmodule

// *** dv/rcs_sequencer_properties.sv ***
// concurrent checks on the sequencer ports, bound to every sequencer instance
`timescale 1ns/1ps
module rcs_sequencer_properties #(
    parameter logic [15:0] POR_PULSE_CYCLES = 16'(rcs_pkg::POR_PULSE_CYC)
) (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic [4:0]  avs_address,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic        avs_waitrequest,
    input wire logic        external_reset_pin_in,
    input wire logic        external_reset_pin_oe,
    input wire logic        brownout_reset_n,
    input wire logic        watchdog_expire,
    input wire logic [3:0]  boot_mode_pins,
    input wire logic [3:0]  boot_mode,
    input wire logic        boot_mode_valid,
    input wire logic        core_reset_n,
    input wire logic        pull_enable,
    input wire logic        clock_output_pin,
    input wire logic [4:0]  sysclk_num,
    input wire logic [3:0]  sysclk_den,
    input wire logic        pll_locking
);
    int         oe_cnt;
    int         hi_cnt;
    int         lo_cnt;
    logic       wd;
    logic [4:0] mult;
    wire        mult_wr = avs_write && !avs_waitrequest && core_reset_n
                          && avs_address == rcs_pkg::OFS_PLL_MULT;
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            oe_cnt <= 0;
            hi_cnt <= 0;
            lo_cnt <= 0;
            wd     <= 1'b0;
            mult   <= 5'h00;
        end else begin
            oe_cnt <= external_reset_pin_oe ? oe_cnt + 1 : 0;
            hi_cnt <= (external_reset_pin_in && !core_reset_n) ? hi_cnt + 1 : 0;
            lo_cnt <= external_reset_pin_in ? 0 : lo_cnt + 1;
            // flag tells a watchdog pulse apart from the power-on pulse
            if (core_reset_n && watchdog_expire)
                wd <= 1'b1;
            else if (!external_reset_pin_oe && oe_cnt != 0)
                wd <= 1'b0;
            if (mult_wr)
                mult <= avs_writedata[4:0];
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // one cycle of slack, config clears just after the core enters reset
    sequence s_held;
        !core_reset_n ##1 !core_reset_n;
    endsequence
    property p_por_rate;
        s_held |-> sysclk_num == 5'h01 && sysclk_den == 4'h4;
    endproperty
    a_por_rate: assert property (p_por_rate) else $error("rate not osc/4");
    property p_out_idle;
        s_held |-> !clock_output_pin;
    endproperty
    a_out_idle: assert property (p_out_idle) else $error("clock output active");
    property p_run_div1;
        $rose(core_reset_n) |-> ##[0:1] sysclk_den == 4'h1 && sysclk_num == 5'h01;
    endproperty
    a_run_div1: assert property (p_run_div1) else $error("no divide-by-one");
    property p_boot;
        $rose(boot_mode_valid) |-> boot_mode == boot_mode_pins;
    endproperty
    a_boot: assert property (p_boot) else $error("boot mode not sampled");
    property p_wdog;
        core_reset_n && watchdog_expire |=> external_reset_pin_oe && !core_reset_n;
    endproperty
    a_wdog: assert property (p_wdog) else $error("watchdog not taken");
    property p_wdog_len;
        $fell(external_reset_pin_oe) && wd |-> oe_cnt >= 511 && oe_cnt <= 513;
    endproperty
    a_wdog_len: assert property (p_wdog_len) else $error("watchdog pulse length");
    property p_por;
        $fell(external_reset_pin_oe) && !wd |->
            oe_cnt >= 30 + POR_PULSE_CYCLES && oe_cnt <= 34 + POR_PULSE_CYCLES;
    endproperty
    a_por: assert property (p_por) else $error("power-on pulse length");
    property p_bus_valid;
        $rose(core_reset_n) |-> hi_cnt >= 32 && hi_cnt <= 37;
    endproperty
    a_bus_valid: assert property (p_bus_valid) else $error("bus valid delay");
    property p_warm;
        $fell(core_reset_n) && !external_reset_pin_oe |-> lo_cnt >= 32;
    endproperty
    a_warm: assert property (p_warm) else $error("warm reset too early");
    property p_lock;
        mult_wr |-> ##2 pll_locking && 2 * sysclk_num == sysclk_den;
    endproperty
    a_lock: assert property (p_lock) else $error("no lock phase");
    property p_rate;
        $fell(pll_locking) && core_reset_n && mult != 5'h00 |->
            ##[0:1] 2 * sysclk_num == mult * sysclk_den;
    endproperty
    a_rate: assert property (p_rate) else $error("wrong rate after lock");
    property p_pull;
        !brownout_reset_n [*5] |-> !pull_enable;
    endproperty
    a_pull: assert property (p_pull) else $error("pulls on in brown-out");
endmodule
bind rcs_sequencer rcs_sequencer_properties #(.POR_PULSE_CYCLES(POR_PULSE_CYCLES)) u_props (
    .ref_clk, .rst_n, .avs_address, .avs_write, .avs_writedata, .avs_waitrequest,
    .external_reset_pin_in, .external_reset_pin_oe, .brownout_reset_n, .watchdog_expire,
    .boot_mode_pins, .boot_mode, .boot_mode_valid, .core_reset_n, .pull_enable,
    .clock_output_pin, .sysclk_num, .sysclk_den, .pll_locking
);

// *** dv/rcs_board.sv ***
// board model: open-drain reset pin with pull-up, boot straps, brown-out
`timescale 1ns/1ps
module rcs_board (
    input  wire logic       ref_clk,
    input  wire logic       pin_oe,
    output logic            pin_level,
    output logic      [3:0] straps,
    output logic            bor_n
);
    logic drive_low = 1'b0;
    // nobody driving leaves the pull-up in charge
    assign pin_level = !(pin_oe || drive_low);
    initial begin
        straps = 4'h5;
        bor_n  = 1'b1;
    end
    // only changed while the core is held, then left alone
    task automatic set_straps(input logic [3:0] v);
        straps <= v;
    endtask
    task automatic pull_low(input int cycles);
        drive_low <= 1'b1;
        repeat (cycles) @(posedge ref_clk);
        drive_low <= 1'b0;
    endtask
    task automatic set_bor(input logic v);
        bor_n <= v;
    endtask
endmodule

// *** dv/reset_clock_sequencer_tb.sv ***
// self-checking bench of the reset and clock sequencer
`timescale 1ns/1ps
module reset_clock_sequencer_tb;
    logic        ref_clk = 1'b0;
    logic        rst_n;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic        wdog;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata, rd;
    logic [3:0]  straps, boot_mode, den;
    logic [4:0]  num;
    logic        wreq, pin_in, pin_out, pin_oe, bor_n, boot_ok, core_n, bus_ok;
    logic        pull_en, clk_out, locking;
    int          failures = 0;
    int          checks_done = 0;
    int          n;
    always #50 ref_clk = ~ref_clk;
    rcs_sequencer #(.POR_PULSE_CYCLES(16'h0010)) u_dut (
        .ref_clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_readdata, .avs_waitrequest(wreq), .external_reset_pin_in(pin_in),
        .external_reset_pin_out(pin_out), .external_reset_pin_oe(pin_oe),
        .brownout_reset_n(bor_n), .watchdog_expire(wdog), .boot_mode_pins(straps),
        .boot_mode, .boot_mode_valid(boot_ok), .core_reset_n(core_n), .bus_valid(bus_ok),
        .pull_enable(pull_en), .clock_output_pin(clk_out), .sysclk_num(num),
        .sysclk_den(den), .pll_locking(locking)
    );
    rcs_board u_board (.ref_clk, .pin_oe, .pin_level(pin_in), .straps, .bor_n);
    task automatic print_verdict();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wrong(input string msg);
        failures++;
        $display("wrong value at %0t ns: %s", $time, msg);
    endtask
    task automatic stop(input string msg);
        wrong(msg);
        print_verdict();
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
            wrong(msg);
    endtask
    // entered just after an edge; the trailing edge keeps strobes apart
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50)
            stop("bus answer timeout");
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic count_while(ref logic s, input logic lvl, input int lim);
        n = 0;
        while (s === lvl && n < lim) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= lim)
            stop("wait timeout");
    endtask
    // window is a whole number of periods, so the count is exact
    task automatic rises(input int exp, input string msg);
        int   r;
        logic prev;
        r = 0;
        repeat (16) @(posedge ref_clk);
        prev = clk_out;
        repeat (64) begin
            @(posedge ref_clk);
            if (clk_out === 1'b1 && prev === 1'b0)
                r++;
            prev = clk_out;
        end
        check(r, exp, msg);
    endtask
    initial begin
        rst_n         <= 1'b0;
        avs_address   <= 5'h00;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        wdog          <= 1'b0;
        avs_writedata <= 32'h0000_0000;
        repeat (5) @(posedge ref_clk);
        check(pin_oe, 1'b1, "pin not held in reset");
        check({num, den}, {5'h01, 4'h4}, "rate in reset");
        rst_n <= 1'b1;
        count_while(pin_oe, 1'b1, 200);
        check(n >= 46 && n <= 50, 1'b1, "power-on pulse length");
        check(pin_out, 1'b0, "pin drive level");
        count_while(core_n, 1'b0, 100);
        @(posedge ref_clk);
        check(boot_mode, 4'h5, "straps");
        check({num, den, bus_ok}, {5'h01, 4'h1, 1'b1}, "run state");
        bus(1'b1, 5'h14, 32'hFFFF_FFFF);
        bus(1'b0, rcs_pkg::OFS_CTRL, 32'h0000_0000);
        check(rd, 32'h0000_0003, "ctrl after boot");
        bus(1'b0, rcs_pkg::OFS_LOCK_PRD, 32'h0000_0000);
        check(rd, {16'h0000, rcs_pkg::LOCK_PRD_RST}, "lock period reset");
        bus(1'b0, 5'h10, 32'h0000_0000);
        check(rd, 32'h0000_0000, "unmapped read");
        rises(0, "output while disabled");
        bus(1'b1, rcs_pkg::OFS_CTRL, 32'h0000_0013);
        rises(16, "output osc/4");
        bus(1'b1, rcs_pkg::OFS_CTRL, 32'h0000_0010);
        rises(4, "output osc/16");
        bus(1'b1, rcs_pkg::OFS_CTRL, 32'h0000_0003);
        bus(1'b1, rcs_pkg::OFS_LOCK_PRD, 32'h0000_2711);
        for (int m = 4; m <= 8; m += 4) begin
            bus(1'b1, rcs_pkg::OFS_PLL_MULT, 32'(m));
            @(posedge ref_clk);
            check(locking && 2 * num == den, 1'b1, "lock phase rate");
            count_while(locking, 1'b1, 10100);
            check(n >= 9997 && n <= 10003, 1'b1, "lock length");
            @(posedge ref_clk);
            check(2 * num == m * den, 1'b1, "rate after lock");
        end
        wdog <= 1'b1;
        @(posedge ref_clk);
        wdog <= 1'b0;
        u_board.set_straps(4'hA);
        @(posedge ref_clk);
        count_while(pin_oe, 1'b1, 600);
        check(n >= 511 && n <= 513, 1'b1, "watchdog pulse");
        count_while(core_n, 1'b0, 100);
        check(boot_mode, 4'hA, "straps after watchdog");
        bus(1'b0, rcs_pkg::OFS_STATUS, 32'h0000_0000);
        check(rd[9:8], rcs_pkg::CAUSE_WDOG, "cause after watchdog");
        u_board.pull_low(10);
        repeat (8) @(posedge ref_clk);
        check(core_n, 1'b1, "short pin pulse");
        u_board.pull_low(40);
        check(core_n, 1'b0, "warm reset");
        count_while(core_n, 1'b0, 100);
        bus(1'b0, rcs_pkg::OFS_STATUS, 32'h0000_0000);
        check(rd[9:8], rcs_pkg::CAUSE_WARM, "cause after warm reset");
        u_board.set_bor(1'b0);
        repeat (6) @(posedge ref_clk);
        check(pull_en, 1'b0, "pulls in brown-out");
        u_board.set_bor(1'b1);
        repeat (6) @(posedge ref_clk);
        check(pull_en, 1'b1, "pulls after brown-out");
        print_verdict();
    end
endmodule
